// >>> logic/rx_serdes_pkg.sv
// Shared constants and carrier types for the receive byte-packing block.
// Assumes one clock domain; all users refer to names as rx_serdes_pkg::name.
package rx_serdes_pkg;

    // Register map on the serial register port
    localparam logic [5:0] ADDR_CTL = 6'h06;
    localparam logic [5:0] ADDR_EN = 6'h07;
    localparam logic [5:0] ADDR_STAT = 6'h08;
    localparam logic [5:0] ADDR_HOLD_A = 6'h09;
    localparam logic [5:0] ADDR_HOLD_B = 6'h0B;

    localparam logic [7:0] CTL_RESET = 8'h03;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    // Upper control bits are not stored and read back as zero
    localparam logic [7:0] CTL_WRITE_MASK = 8'h0F;
    localparam int unsigned CTL_BYTE_MODE = 3;
    localparam int unsigned CTL_GAP_MSB = 2;

    // Per-channel nibble layout in the enable and status registers
    localparam int unsigned CH_NIBBLE = 4;
    localparam int unsigned F_FULL = 0;
    localparam int unsigned F_EOF = 1;
    localparam int unsigned F_OVER = 2;
    localparam int unsigned F_UNDER = 3;
    localparam int unsigned F_FLOW = 2;
    localparam int unsigned F_VALID = 3;

    // Serial register frame: command byte then data byte, MSB first
    localparam int unsigned SPI_WRITE_BIT = 7;
    localparam logic [3:0] SPI_BYTE_LAST = 4'h7;
    localparam logic [3:0] BYTE_LAST = 4'h7;

    typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_DATA} spi_phase_t;

    // One bit time from both correlators
    typedef struct packed {
        logic validB;
        logic dataB;
        logic validA;
        logic dataA;
    } corr_bit_t;

    // What a channel receiver reports after a bit time
    typedef struct packed {
        logic load;
        logic eof;
        logic allValid;
        logic [7:0] data;
    } rx_event_t;

    // Bit position of a field for channel A (0) or B (1)
    function automatic int unsigned fieldPos(input logic chB,
                                             input int unsigned field);
        fieldPos = (chB ? CH_NIBBLE : 0) + field;
    endfunction : fieldPos

    function automatic logic [5:0] holdAddr(input logic chB);
        holdAddr = chB ? ADDR_HOLD_B : ADDR_HOLD_A;
    endfunction : holdAddr

endpackage : rx_serdes_pkg

// >>> logic/bit_skid_buffer.sv
// Two-entry buffer for correlator bit times between source and receivers.
// Assumes a synchronous active-high reset; source honours inReady.
`timescale 1ns/1ps
`default_nettype none
module bit_skid_buffer (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic inValid,
    input wire rx_serdes_pkg::corr_bit_t inData,
    output logic inReady,
    output logic outValid,
    output rx_serdes_pkg::corr_bit_t outData,
    input wire logic outReady
);
    typedef struct packed {
        rx_serdes_pkg::corr_bit_t [1:0] mem;
        logic wrPtr;
        logic rdPtr;
        logic [1:0] count;
        logic ready;
    } buf_state_t;

    buf_state_t st;
    buf_state_t next_st;
    logic push;
    logic pop;

    always_comb begin
        next_st = st;
        push = inValid && st.ready;
        pop = (st.count != 2'h0) && outReady;
        if (push) begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = !st.wrPtr;
        end
        if (pop) begin
            next_st.rdPtr = !st.rdPtr;
        end
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};
        // Ready is registered so the source sees no combinational path
        next_st.ready = (next_st.count != 2'h2);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign inReady = st.ready;
    assign outValid = (st.count != 2'h0);
    assign outData = st.mem[st.rdPtr];

    chk_buf_no_overfill: assert property (@(posedge clk_sys) disable iff (reset)
        st.count == 2'h2 |-> !st.ready)
        else $error("buffer full but still ready");
endmodule : bit_skid_buffer
`default_nettype wire

// >>> logic/rx_channel.sv
// One channel receiver: packs valid bits into bytes and finds end of frame.
// Assumes tick marks one bit time; gapLen is the programmed gap threshold.
`timescale 1ns/1ps
`default_nettype none
module rx_channel (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic tick,
    input wire logic bitValid,
    input wire logic bitData,
    input wire logic [2:0] gapLen,
    output rx_serdes_pkg::rx_event_t ev
);
    typedef struct packed {
        logic [7:0] shiftReg;
        logic [3:0] bitCount;
        logic [3:0] gapCount;
        logic seen;
        logic anyInvalid;
        rx_serdes_pkg::rx_event_t ev;
    } ch_state_t;

    ch_state_t st;
    ch_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.ev.load = 1'b0;
        next_st.ev.eof = 1'b0;
        if (tick && bitValid) begin
            next_st.seen = 1'b1;
            next_st.gapCount = 4'h0;
            next_st.shiftReg = {st.shiftReg[6:0], bitData};
            next_st.bitCount = st.bitCount + 4'h1;
            if (st.bitCount == rx_serdes_pkg::BYTE_LAST) begin
                next_st.ev.load = 1'b1;
                next_st.ev.data = {st.shiftReg[6:0], bitData};
                next_st.ev.allValid = !st.anyInvalid;
                next_st.bitCount = 4'h0;
                next_st.anyInvalid = 1'b0;
                // Each byte starts empty so a flushed partial byte is clean
                next_st.shiftReg = 8'h00;
            end
        end else if (tick && st.seen) begin
            // End of frame once the invalid run exceeds the threshold
            next_st.anyInvalid = 1'b1;
            if (st.gapCount >= {1'b0, gapLen}) begin
                next_st.ev.eof = 1'b1;
                next_st.seen = 1'b0;
                next_st.gapCount = 4'h0;
                next_st.anyInvalid = 1'b0;
                next_st.bitCount = 4'h0;
                next_st.shiftReg = 8'h00;
                if (st.bitCount != 4'h0) begin
                    // Partial byte flushed on end of frame
                    next_st.ev.load = 1'b1;
                    next_st.ev.data = st.shiftReg;
                    next_st.ev.allValid = 1'b0;
                end
            end else begin
                next_st.gapCount = st.gapCount + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ev = st.ev;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_eof_gap_zero: assert property (
        tick && !bitValid && st.seen && gapLen == 3'h0 |=> ev.eof)
        else $error("zero gap did not end frame on first invalid bit");
    chk_eof_needs_valid: assert property (
        !st.seen |=> !ev.eof)
        else $error("end of frame without prior valid bit");
    chk_gap_count_hold: assert property (
        tick && !bitValid && st.seen && st.gapCount < {1'b0, gapLen}
        |=> !ev.eof)
        else $error("end of frame before gap threshold exceeded");
endmodule : rx_channel
`default_nettype wire

// >>> logic/rx_serdes_frame_irq_ctrl.sv
// Receive byte packing, end-of-frame and interrupt control, two channels.
// Assumes serial register port pins and correlator bits are synchronous
// to clk_sys; the host samples spiMiso on rising spiClk (mode 0).
//
// How it works
// - Control bit 3 picks byte holding registers (1) or bit pins (0).
// - Gap threshold comes from control bits 2:0.
// - End of frame follows a valid bit, then invalid bits exceeding threshold.
// - Zero threshold ends the frame on the first invalid bit.
// - End of frame moves partial data to the holding register; may interrupt.
// - Enable bit 7 gates channel B underflow interrupt.
// - Reading empty channel B holding register at 0x0B flags underflow.
// - Enable bit 6 gates channel B overflow interrupt.
// - Loading channel B holding register before it was read flags overflow.
// - Enable bit 5 gates channel B end-of-frame interrupt while present.
// - Reading the status register clears pending end of frame.
// - Enable bit 4 gates channel B full interrupt.
// - Holding register loads on a whole byte or partial byte at frame end.
// - Enable bits 3:0 do the same for channel A at 0x09.
// - Status register at 0x08 resets to zero, holds per-channel flags.
`timescale 1ns/1ps
`default_nettype none
module rx_serdes_frame_irq_ctrl (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic spiClk,
    input wire logic spiSelectN,
    input wire logic spiMosi,
    output logic spiMiso,
    input wire rx_serdes_pkg::corr_bit_t corrBit,
    input wire logic corrBitValid,
    output logic corrBitReady,
    output logic irq,
    output logic serialBitPinOut,
    output logic serialBitPinOe,
    output logic serialBitValidPinOut,
    output logic serialBitValidPinOe
);
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] en;
        logic [1:0][7:0] holdData;
        logic [1:0] holdFull;
        logic [1:0] holdValid;
        logic [1:0] eofFlag;
        logic [1:0] overFlag;
        logic [1:0] underFlag;
        rx_serdes_pkg::spi_phase_t phase;
        logic [3:0] bitCnt;
        logic [7:0] rxShift;
        logic [7:0] cmd;
        logic [7:0] txShift;
        logic sclkPrev;
        logic miso;
        logic irq;
        logic pinData;
        logic pinValid;
        logic pinOe;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic bufValid;
    rx_serdes_pkg::corr_bit_t bufData;
    logic drainReady;
    logic tick;
    rx_serdes_pkg::rx_event_t evA;
    rx_serdes_pkg::rx_event_t evB;

    logic rdStrobe;
    logic wrStrobe;
    logic statRead;
    logic [1:0] rdHold;
    logic [5:0] accAddr;
    logic [7:0] newByte;
    logic [7:0] condVec;
    rx_serdes_pkg::rx_event_t ev [2];

    function automatic logic [7:0] statusValue(input top_state_t s);
        logic [7:0] v;
        v = rx_serdes_pkg::STAT_RESET;
        for (int c = 0; c < 2; c++) begin
            v[rx_serdes_pkg::fieldPos(c[0], rx_serdes_pkg::F_VALID)] =
                s.holdValid[c];
            v[rx_serdes_pkg::fieldPos(c[0], rx_serdes_pkg::F_FLOW)] =
                s.overFlag[c] | s.underFlag[c];
            v[rx_serdes_pkg::fieldPos(c[0], rx_serdes_pkg::F_EOF)] =
                s.eofFlag[c];
            v[rx_serdes_pkg::fieldPos(c[0], rx_serdes_pkg::F_FULL)] =
                s.holdFull[c];
        end
        statusValue = v;
    endfunction : statusValue

    function automatic logic [7:0] readValue(input top_state_t s,
                                             input logic [5:0] addr);
        case (addr)
            rx_serdes_pkg::ADDR_CTL: readValue = s.ctl;
            rx_serdes_pkg::ADDR_EN: readValue = s.en;
            rx_serdes_pkg::ADDR_STAT: readValue = statusValue(s);
            rx_serdes_pkg::ADDR_HOLD_A: readValue = s.holdData[0];
            rx_serdes_pkg::ADDR_HOLD_B: readValue = s.holdData[1];
            default: readValue = 8'h00;
        endcase
    endfunction : readValue

    bit_skid_buffer u_buffer (
        .clk_sys(clk_sys),
        .reset(reset),
        .inValid(corrBitValid),
        .inData(corrBit),
        .inReady(corrBitReady),
        .outValid(bufValid),
        .outData(bufData),
        .outReady(drainReady)
    );

    rx_channel u_chan_a (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick(tick),
        .bitValid(bufData.validA),
        .bitData(bufData.dataA),
        .gapLen(st.ctl[rx_serdes_pkg::CTL_GAP_MSB:0]),
        .ev(evA)
    );

    rx_channel u_chan_b (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick(tick),
        .bitValid(bufData.validB),
        .bitData(bufData.dataB),
        .gapLen(st.ctl[rx_serdes_pkg::CTL_GAP_MSB:0]),
        .ev(evB)
    );

    always_comb begin
        next_st = st;
        rdStrobe = 1'b0;
        wrStrobe = 1'b0;
        ev[0] = evA;
        ev[1] = evB;
        newByte = {st.rxShift[6:0], spiMosi};
        next_st.sclkPrev = spiClk;
        if (spiSelectN) begin
            next_st.phase = rx_serdes_pkg::SPI_IDLE;
            next_st.bitCnt = 4'h0;
            next_st.miso = 1'b0;
        end else if (spiClk && !st.sclkPrev) begin
            next_st.rxShift = newByte;
            next_st.bitCnt = st.bitCnt + 4'h1;
            if (st.phase == rx_serdes_pkg::SPI_IDLE) begin
                next_st.phase = rx_serdes_pkg::SPI_CMD;
            end
            if (st.bitCnt == rx_serdes_pkg::SPI_BYTE_LAST) begin
                next_st.bitCnt = 4'h0;
                if (st.phase != rx_serdes_pkg::SPI_DATA) begin
                    next_st.cmd = newByte;
                    next_st.phase = rx_serdes_pkg::SPI_DATA;
                    if (!newByte[rx_serdes_pkg::SPI_WRITE_BIT]) begin
                        // Read side effects happen when the command lands
                        rdStrobe = 1'b1;
                        next_st.txShift = readValue(st, newByte[5:0]);
                    end
                end else begin
                    next_st.phase = rx_serdes_pkg::SPI_CMD;
                    wrStrobe = st.cmd[rx_serdes_pkg::SPI_WRITE_BIT];
                end
            end
        end else if (!spiClk && st.sclkPrev
                     && st.phase == rx_serdes_pkg::SPI_DATA
                     && !st.cmd[rx_serdes_pkg::SPI_WRITE_BIT]) begin
            next_st.miso = st.txShift[7];
            next_st.txShift = {st.txShift[6:0], 1'b0};
        end

        accAddr = rdStrobe ? newByte[5:0] : st.cmd[5:0];
        if (wrStrobe) begin
            case (accAddr)
                rx_serdes_pkg::ADDR_CTL: begin
                    // Reserved upper bits are dropped, not stored
                    next_st.ctl = newByte & rx_serdes_pkg::CTL_WRITE_MASK;
                end
                rx_serdes_pkg::ADDR_EN: begin
                    next_st.en = newByte;
                end
                default: begin
                end
            endcase
        end

        statRead = rdStrobe && accAddr == rx_serdes_pkg::ADDR_STAT;
        if (statRead) begin
            next_st.eofFlag = 2'b00;
            next_st.overFlag = 2'b00;
            next_st.underFlag = 2'b00;
        end

        for (int c = 0; c < 2; c++) begin
            rdHold[c] = rdStrobe && accAddr == rx_serdes_pkg::holdAddr(c[0]);
            if (rdHold[c]) begin
                if (!st.holdFull[c]) begin
                    next_st.underFlag[c] = 1'b1;
                end
                next_st.holdFull[c] = 1'b0;
            end
            // Loads come after the read clear so a new byte is never lost
            if (ev[c].load && st.ctl[rx_serdes_pkg::CTL_BYTE_MODE]) begin
                if (st.holdFull[c] && !rdHold[c]) begin
                    next_st.overFlag[c] = 1'b1;
                end
                next_st.holdData[c] = ev[c].data;
                next_st.holdFull[c] = 1'b1;
                next_st.holdValid[c] = ev[c].allValid;
            end
            if (ev[c].eof) begin
                next_st.eofFlag[c] = 1'b1;
            end
        end

        // Stall the correlator stream while a holding register is read,
        // so no byte load lands in the cycle right after a holding register read
        drainReady = !(|rdHold);
        tick = bufValid && drainReady;

        next_st.pinOe = !next_st.ctl[rx_serdes_pkg::CTL_BYTE_MODE];
        if (tick && !st.ctl[rx_serdes_pkg::CTL_BYTE_MODE]) begin
            next_st.pinData = bufData.dataA;
            next_st.pinValid = bufData.validA;
        end

        condVec = 8'h00;
        for (int c = 0; c < 2; c++) begin
            condVec[rx_serdes_pkg::fieldPos(c[0], rx_serdes_pkg::F_UNDER)] =
                next_st.underFlag[c];
            condVec[rx_serdes_pkg::fieldPos(c[0], rx_serdes_pkg::F_OVER)] =
                next_st.overFlag[c];
            condVec[rx_serdes_pkg::fieldPos(c[0], rx_serdes_pkg::F_EOF)] =
                next_st.eofFlag[c];
            condVec[rx_serdes_pkg::fieldPos(c[0], rx_serdes_pkg::F_FULL)] =
                next_st.holdFull[c];
        end
        next_st.irq = |(condVec & next_st.en);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
            st.ctl <= rx_serdes_pkg::CTL_RESET;
            st.en <= rx_serdes_pkg::EN_RESET;
            st.phase <= rx_serdes_pkg::SPI_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign spiMiso = st.miso;
    assign irq = st.irq;
    assign serialBitPinOut = st.pinData;
    assign serialBitPinOe = st.pinOe;
    assign serialBitValidPinOut = st.pinValid;
    assign serialBitValidPinOe = st.pinOe;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_irq_masked_off: assert property (
        st.en == 8'h00 |-> !irq)
        else $error("interrupt raised with every enable clear");
    chk_under_b_flag: assert property (
        rdHold[1] && !st.holdFull[1] |=> st.underFlag[1])
        else $error("empty channel B read did not flag underflow");
    chk_over_b_flag: assert property (
        evB.load && st.ctl[rx_serdes_pkg::CTL_BYTE_MODE] && st.holdFull[1]
        && !rdHold[1] |=> st.overFlag[1])
        else $error("channel B overwrite did not flag overflow");
    chk_full_b_load: assert property (
        evB.load && st.ctl[rx_serdes_pkg::CTL_BYTE_MODE]
        |=> st.holdFull[1] && st.holdData[1] == $past(evB.data))
        else $error("channel B holding register not loaded");
    chk_eof_cleared: assert property (
        statRead && !evA.eof |=> !st.eofFlag[0])
        else $error("status read left end of frame pending");
    chk_eof_irq_b: assert property (
        st.en[rx_serdes_pkg::fieldPos(1'b1, rx_serdes_pkg::F_EOF)]
        && st.eofFlag[1] |-> irq)
        else $error("enabled channel B end of frame gave no interrupt");
    chk_mode_pins: assert property (
        st.ctl[rx_serdes_pkg::CTL_BYTE_MODE] |=> ##1 !serialBitPinOe
        || !$past(st.ctl[rx_serdes_pkg::CTL_BYTE_MODE]))
        else $error("bit pins driven in byte mode");
    chk_bit_mode_no_load: assert property (
        !st.ctl[rx_serdes_pkg::CTL_BYTE_MODE] && !rdHold[0]
        |=> st.holdFull[0] == $past(st.holdFull[0]))
        else $error("holding register changed in bit mode");
    chk_ctl_upper_zero: assert property (
        st.ctl[7:4] == 4'h0)
        else $error("reserved control bits stored");

    cov_eof_b: cover property (evB.eof);
    cov_overflow_a: cover property (!st.overFlag[0] ##1 st.overFlag[0]);
    cov_underflow_b: cover property (rdHold[1] && !st.holdFull[1]);
    cov_irq_rise: cover property (!irq ##1 irq);
endmodule : rx_serdes_frame_irq_ctrl
`default_nettype wire

// >>> test/host_spi_model.sv
// Host model on the serial register port: mode 0, MSB first, 16-bit frames.
// Assumes the device samples spiClk on clk_sys, two cycles per phase or more.
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
    input wire logic clk_sys,
    output logic spiClk,
    output logic spiSelectN,
    output logic spiMosi,
    input wire logic spiMiso
);
    initial begin
        spiClk = 1'b0;
        spiSelectN = 1'b1;
        spiMosi = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : hold
    // Three cycles a phase so that no edge slips past the device
    task automatic access(input logic wr, input logic [5:0] a,
            input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] frame;
        frame = {wr, 1'b0, a, wd};
        rd = 8'h00;
        hold(1);
        spiSelectN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spiMosi = frame[i];
            hold(3);
            spiClk = 1'b1;
            rd = {rd[6:0], spiMiso};
            hold(3);
            spiClk = 1'b0;
        end
        hold(3);
        spiSelectN = 1'b1;
        // Idle line never repeats the last bit
        spiMosi = ~spiMosi;
    endtask : access
endmodule : host_spi_model
`default_nettype wire

// >>> test/test_rx_serdes_frame_irq_ctrl.sv
// Bench for the receive byte-packing block; correlator bits driven here.
// Assumes the host model sits on the register port.
`timescale 1ns/1ps
`default_nettype none
module test_rx_serdes_frame_irq_ctrl;
    localparam logic [5:0] CTL = rx_serdes_pkg::ADDR_CTL;
    localparam logic [5:0] EN = rx_serdes_pkg::ADDR_EN;
    localparam logic [5:0] STAT = rx_serdes_pkg::ADDR_STAT;
    localparam logic [5:0] HA = rx_serdes_pkg::ADDR_HOLD_A;
    localparam logic [5:0] HB = rx_serdes_pkg::ADDR_HOLD_B;
    logic clk_sys, reset, spiClk, spiSelectN, spiMosi, spiMiso;
    logic corrBitValid, corrBitReady, irq, pinOut, pinOe, valOut, valOe;
    rx_serdes_pkg::corr_bit_t corrBit;
    logic [7:0] rdat;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;

    rx_serdes_frame_irq_ctrl rx_serdes_frame_irq_ctrl_i (
        .clk_sys(clk_sys), .reset(reset), .spiClk(spiClk),
        .spiSelectN(spiSelectN), .spiMosi(spiMosi), .spiMiso(spiMiso),
        .corrBit(corrBit), .corrBitValid(corrBitValid),
        .corrBitReady(corrBitReady), .irq(irq),
        .serialBitPinOut(pinOut), .serialBitPinOe(pinOe),
        .serialBitValidPinOut(valOut), .serialBitValidPinOe(valOe)
    );
    host_spi_model host_spi_model_i (
        .clk_sys(clk_sys), .spiClk(spiClk), .spiSelectN(spiSelectN),
        .spiMosi(spiMosi), .spiMiso(spiMiso)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic end_of_test;
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        if (a == CTL) d = d & rx_serdes_pkg::CTL_WRITE_MASK;
        host_spi_model_i.access(1'b1, a, d, rdat);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        host_spi_model_i.access(1'b0, a, 8'h00, rdat);
        check(rdat, exp);
    endtask : rd
    task automatic peek(input logic [5:0] a);
        host_spi_model_i.access(1'b0, a, 8'h00, rdat);
    endtask : peek
    task automatic send(input logic [3:0] b);
        corrBit = b;
        corrBitValid = 1'b1;
        // Ready is looked at off the edge, where it is settled
        for (int i = 0; i < 50 && corrBitReady !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1;
    endtask : send
    // Lets the pipeline drain; data flips so nothing stale looks offered
    task automatic idle;
        corrBit = ~corrBit;
        corrBitValid = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask : idle
    task automatic sendByte(input logic [7:0] a, b, input logic va);
        for (int i = 7; i >= 0; i--) send({1'b1, b[i], va, a[i]});
        idle();
    endtask : sendByte

    task automatic t_reset;
        rd(CTL, 8'h03);
        rd(EN, 8'h00);
        rd(STAT, 8'h00);
        rd(6'h10, 8'h00);
        check({6'h00, pinOe, valOe}, 8'h03);
        send(4'b0011);
        idle();
        check({6'h00, pinOut, valOut}, 8'h03);
        for (int i = 0; i < 4; i++) send(4'b0000);
        idle();
        check({6'h00, pinOut, valOut}, 8'h00);
        rd(STAT, 8'h02);
    endtask : t_reset
    task automatic t_bytes;
        wr(CTL, 8'h0F);
        check({6'h00, pinOe, valOe}, 8'h00);
        wr(EN, 8'h11);
        sendByte(8'hA5, 8'h3C, 1'b1);
        check({7'h00, irq}, 8'h01);
        rd(STAT, 8'h99);
        rd(HA, 8'hA5);
        rd(HB, 8'h3C);
        check({7'h00, irq}, 8'h00);
    endtask : t_bytes
    task automatic t_partial;
        wr(CTL, 8'h0A);
        wr(EN, 8'h22);
        send(4'b1011);
        send(4'b1110);
        send(4'b1111);
        send(4'b0000);
        send(4'b0000);
        idle();
        rd(STAT, 8'h88);
        check({7'h00, irq}, 8'h00);
        send(4'b0000);
        idle();
        check({7'h00, irq}, 8'h01);
        rd(STAT, 8'h33);
        check({7'h00, irq}, 8'h00);
        rd(HA, 8'h05);
        rd(HB, 8'h03);
    endtask : t_partial
    task automatic t_gap0;
        wr(CTL, 8'h08);
        wr(EN, 8'h02);
        send(4'b0011);
        send(4'b0000);
        idle();
        check({7'h00, irq}, 8'h01);
        rd(STAT, 8'h03);
        rd(HA, 8'h01);
    endtask : t_gap0
    task automatic t_flow;
        wr(EN, 8'h00);
        peek(HB);
        check({7'h00, irq}, 8'h00);
        rd(STAT, 8'h40);
        wr(EN, 8'h80);
        peek(HB);
        check({7'h00, irq}, 8'h01);
        rd(STAT, 8'h40);
        wr(EN, 8'h08);
        peek(HA);
        check({7'h00, irq}, 8'h01);
        rd(STAT, 8'h04);
        wr(EN, 8'h40);
        sendByte(8'h00, 8'h11, 1'b0);
        check({7'h00, irq}, 8'h00);
        sendByte(8'h00, 8'h22, 1'b0);
        check({7'h00, irq}, 8'h01);
        rd(STAT, 8'hD0);
        rd(HB, 8'h22);
        check({7'h00, irq}, 8'h00);
    endtask : t_flow

    initial begin
        reset = 1'b1;
        corrBit = 4'h0;
        corrBitValid = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        t_reset();
        t_bytes();
        t_partial();
        t_gap0();
        t_flow();
        end_of_test();
    end
endmodule : test_rx_serdes_frame_irq_ctrl
`default_nettype wire
